// File: verilog/omc_pkg.sv
package omc_pkg;
    // register indices on the plain register port
    localparam logic [3:0] OMC_ADDR_SYSCTL = 4'h0;  // system control register
    localparam logic [3:0] OMC_ADDR_MODE = 4'h1;    // latched mode, read only
    localparam logic [3:0] OMC_ADDR_AREAW = 4'h2;   // per-area 16-bit access bits
    localparam logic [3:0] OMC_ADDR_EXTCTL = 4'h3;  // bit 0 external_area_extension
    localparam logic [3:0] OMC_ADDR_STATUS = 4'h4;  // resolved configuration
    localparam logic [3:0] OMC_ADDR_NMI = 4'h5;     // nmi pending, write 1 to clear

    // system control register fields
    localparam int OMC_SYS_ONCHIP_RAM_ENABLE_BIT = 0;
    localparam int OMC_SYS_RSV1_BIT = 1;
    localparam int OMC_SYS_RSV2_BIT = 2;
    localparam int OMC_SYS_NMI_EDGE_SELECT_BIT = 3;
    localparam logic [7:0] OMC_SYS_WMASK = 8'hbb;   // bits 2 and 6 not writable
    localparam logic [7:0] OMC_SYS_RESET = 8'h01;
    localparam logic [7:0] OMC_AREAW_RESET_MODE4 = 8'hff;
    localparam logic [7:0] OMC_AREAW_RESET_OTHER = 8'h00;
    localparam logic OMC_EAE_RESET = 1'b1;

    // status register fields
    localparam int OMC_ST_ADV_BIT = 0;
    localparam int OMC_ST_ROM_BIT = 1;
    localparam int OMC_ST_BUS16_BIT = 2;
    localparam int OMC_ST_EXT_BIT = 3;
    localparam int OMC_ST_VALID_BIT = 4;

    // ROM limits in kbytes
    localparam logic [7:0] OMC_ROM_KB_FULL = 8'd64;
    localparam logic [7:0] OMC_ROM_KB_NORMAL = 8'd56;
    localparam logic [7:0] OMC_ROM_KB_WIDE = 8'd128;

    typedef enum logic [1:0] {
        OMC_PIN_IO,
        OMC_PIN_ADDR,
        OMC_PIN_DATA,
        OMC_PIN_CTRL
    } omc_pinfn_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } omc_req_s;

    typedef struct packed {
        logic advanced;         // 16-Mbyte space
        logic rom_enable;
        logic [7:0] rom_kbytes; // usable on-chip ROM
        logic bus16;
        logic ext_allowed;      // external address accesses permitted
        logic ram_enable;       // on-chip RAM decoded
        logic ram_to_external;  // RAM range routed to external space
        logic upper_rom_reserved;
        logic eight_areas;
    } omc_cfg_s;

    typedef struct packed {
        omc_pinfn_e [7:0] a;
        omc_pinfn_e [7:0] b;
        omc_pinfn_e [7:0] c;
        omc_pinfn_e [7:0] d;
        omc_pinfn_e [7:0] e;
        omc_pinfn_e [7:0] f;
    } omc_pins_s;
endpackage

// File: verilog/omc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module omc_sync2 #(
    parameter int W = 1
) (
    input wire logic clock,        // system clock
    input wire logic [W-1:0] din,  // asynchronous inputs
    output logic [W-1:0] dout      // synchronised outputs
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } omc_sync_s;

    omc_sync_s st_q;
    omc_sync_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    // no reset: live pin levels must be ready on the first edge after reset lifts
    always_ff @(posedge clock) begin
        st_q <= st_d;
    end

    assign dout = st_q.s2;
endmodule // omc_sync2

`default_nettype wire

// File: verilog/omc_top.sv
// What this block does
// - any 16-bit area forces 16-bit bus in expanded modes 1,2,4,5,6
// - nmi edge select: 0 falling, 1 rising
// - bit 2 reads zero, ignores writes
// - RAM enable bit, resets to one
// - RAM disabled routes range to external in expanded modes 1,2,4,5,6
// - mode 1: 64k, no ROM, starts 8-bit
// - modes 1,2,5 16-bit makes port E data
// - mode 2: ROM, ports B,C by direction
// - modes 2,3 limit ROM to 56k
// - modes 3,7 ROM, no external, all I/O
// - 64k in modes 1-3, 16M in 4-7
// - mode 4: no ROM, starts 16-bit
// - mode 5: no ROM, starts 8-bit
// - mode 6: ROM, ports A,B,C by direction
// - advanced modes use eight areas
// - modes 6,7 ROM 64k, extension clear gives 128k
// - upper ROM reserved while extension set
`timescale 1ns/1ps
`default_nettype none
module omc_top
    import omc_pkg::*;
(
    input wire logic clock,                 // system clock
    input wire logic rst,                   // synchronous reset
    input wire logic [2:0] mode_select_pins,// strapped mode pins
    input wire logic nmi_pin,               // raw nmi input
    input wire logic standby,               // software standby in progress
    input wire logic [7:0] ddr_a,           // port A direction bits
    input wire logic [7:0] ddr_b,           // port B direction bits
    input wire logic [7:0] ddr_c,           // port C direction bits
    input wire omc_pkg::omc_req_s req,      // register request
    output logic [7:0] rdata,               // read data, one cycle after read
    output omc_pkg::omc_cfg_s cfg,          // resolved configuration
    output omc_pkg::omc_pins_s pins,        // per-pin function
    output logic nmi_request,               // one-cycle nmi request pulse
    output logic [2:0] mode                 // latched operating mode
);
    import omc_pkg::*;

    typedef struct packed {
        logic [7:0] sysctl;
        logic [7:0] areaw;
        logic eae;
        logic [2:0] mode;
        logic captured;
        logic nmi_prev;
        logic nmi_pend;
        logic nmi_req;
        logic [7:0] rdata;
    } omc_state_s;

    omc_state_s st_q;
    omc_state_s st_d;
    logic [2:0] mode_sync;
    logic nmi_sync;
    logic nmi_edge;
    logic is_adv;
    logic rom_on;
    logic expanded;
    logic bus16;
    logic [7:0] status_word;

    omc_sync2 #(.W(4)) u_sync (
        .clock(clock),
        .din({nmi_pin, mode_select_pins}),
        .dout({nmi_sync, mode_sync})
    );

    function automatic omc_pinfn_e dir_pin(input logic dir);
        dir_pin = dir ? OMC_PIN_ADDR : OMC_PIN_IO;
    endfunction

    function automatic logic mode_in(input logic [2:0] m, input logic [7:0] set);
        mode_in = set[m];
    endfunction

    // mode decode
    always_comb begin
        is_adv = st_q.mode[2];
        rom_on = mode_in(st_q.mode, 8'hcc);
        expanded = mode_in(st_q.mode, 8'h76);
        if (st_q.mode == 3'h4) begin
            bus16 = st_q.areaw != 8'h00;
        end else begin
            bus16 = expanded && (st_q.areaw != 8'h00);
        end
    end

    always_comb begin
        cfg.advanced = is_adv;
        cfg.rom_enable = rom_on;
        if (mode_in(st_q.mode, 8'h0c)) begin
            cfg.rom_kbytes = OMC_ROM_KB_NORMAL;
        end else if (mode_in(st_q.mode, 8'hc0) && !st_q.eae) begin
            cfg.rom_kbytes = OMC_ROM_KB_WIDE;
        end else if (rom_on) begin
            cfg.rom_kbytes = OMC_ROM_KB_FULL;
        end else begin
            cfg.rom_kbytes = 8'h00;
        end
        cfg.bus16 = bus16;
        cfg.ext_allowed = expanded;
        cfg.ram_enable = st_q.sysctl[OMC_SYS_ONCHIP_RAM_ENABLE_BIT];
        cfg.ram_to_external = expanded && !st_q.sysctl[OMC_SYS_ONCHIP_RAM_ENABLE_BIT];
        cfg.upper_rom_reserved = st_q.eae;
        cfg.eight_areas = is_adv;
    end

    // pin function per port
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pins.a[i] = OMC_PIN_IO;
            pins.b[i] = OMC_PIN_IO;
            pins.c[i] = OMC_PIN_IO;
            pins.d[i] = OMC_PIN_IO;
            pins.e[i] = OMC_PIN_IO;
            pins.f[i] = OMC_PIN_IO;
        end
        for (int i = 0; i < 8; i++) begin
            case (st_q.mode)
                3'h1: begin
                    pins.b[i] = OMC_PIN_ADDR;
                    pins.c[i] = OMC_PIN_ADDR;
                end
                3'h2: begin
                    pins.b[i] = dir_pin(ddr_b[i]);
                    pins.c[i] = dir_pin(ddr_c[i]);
                end
                3'h4, 3'h5: begin
                    pins.a[i] = (i < 5) ? OMC_PIN_ADDR : dir_pin(ddr_a[i]);
                    pins.b[i] = OMC_PIN_ADDR;
                    pins.c[i] = OMC_PIN_ADDR;
                end
                3'h6: begin
                    pins.a[i] = dir_pin(ddr_a[i]);
                    pins.b[i] = dir_pin(ddr_b[i]);
                    pins.c[i] = dir_pin(ddr_c[i]);
                end
                default: begin
                    pins.a[i] = OMC_PIN_IO;
                end
            endcase
            if (expanded) begin
                pins.d[i] = OMC_PIN_DATA;
                pins.e[i] = bus16 ? OMC_PIN_DATA : OMC_PIN_IO;
                // pins 7..3 control; 2..0 stay I/O after reset
                if (i >= 3) begin
                    pins.f[i] = OMC_PIN_CTRL;
                end
            end
        end
    end

    assign nmi_edge = st_q.sysctl[OMC_SYS_NMI_EDGE_SELECT_BIT] ?
        (nmi_sync && !st_q.nmi_prev) : (!nmi_sync && st_q.nmi_prev);

    always_comb begin
        status_word = 8'h00;
        status_word[OMC_ST_ADV_BIT] = is_adv;
        status_word[OMC_ST_ROM_BIT] = rom_on;
        status_word[OMC_ST_BUS16_BIT] = bus16;
        status_word[OMC_ST_EXT_BIT] = expanded;
        status_word[OMC_ST_VALID_BIT] = st_q.mode != 3'h0;
    end

    always_comb begin
        st_d = st_q;
        st_d.nmi_prev = nmi_sync;
        st_d.nmi_req = nmi_edge;
        st_d.rdata = 8'h00;
        // mode pins sampled once after reset and held
        if (!st_q.captured) begin
            st_d.mode = mode_sync;
            st_d.captured = 1'b1;
            st_d.areaw = (mode_sync == 3'h4) ? OMC_AREAW_RESET_MODE4
                : OMC_AREAW_RESET_OTHER;
        end
        if (req.wr) begin
            if (req.addr == OMC_ADDR_SYSCTL) begin
                // reserved bit 2 keeps zero; standby does not disturb RAM enable
                st_d.sysctl = req.wdata & OMC_SYS_WMASK;
            end else if (req.addr == OMC_ADDR_AREAW) begin
                st_d.areaw = req.wdata;
            end else if (req.addr == OMC_ADDR_EXTCTL) begin
                st_d.eae = req.wdata[0];
            end else if (req.addr == OMC_ADDR_NMI) begin
                if (req.wdata[0]) begin
                    st_d.nmi_pend = 1'b0;
                end
            end
        end
        if (nmi_edge) begin
            st_d.nmi_pend = 1'b1;
        end
        if (req.rd) begin
            if (req.addr == OMC_ADDR_SYSCTL) begin
                st_d.rdata = st_q.sysctl;
            end else if (req.addr == OMC_ADDR_MODE) begin
                st_d.rdata = {5'h00, st_q.mode};
            end else if (req.addr == OMC_ADDR_AREAW) begin
                st_d.rdata = st_q.areaw;
            end else if (req.addr == OMC_ADDR_EXTCTL) begin
                st_d.rdata = {7'h00, st_q.eae};
            end else if (req.addr == OMC_ADDR_STATUS) begin
                st_d.rdata = status_word;
            end else if (req.addr == OMC_ADDR_NMI) begin
                st_d.rdata = {7'h00, st_q.nmi_pend};
            end else begin
                st_d.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q.sysctl <= OMC_SYS_RESET;
            st_q.areaw <= OMC_AREAW_RESET_OTHER;
            st_q.eae <= OMC_EAE_RESET;
            st_q.mode <= 3'h0;
            st_q.captured <= 1'b0;
            st_q.nmi_prev <= 1'b0;
            st_q.nmi_pend <= 1'b0;
            st_q.nmi_req <= 1'b0;
            st_q.rdata <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign nmi_request = st_q.nmi_req;
    assign mode = st_q.mode;
endmodule // omc_top

`default_nettype wire

// File: dv/omc_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module omc_ext_model (
    input wire logic [2:0] strap,        // chosen mode code
    input wire logic nmi_lvl,            // requested nmi level
    output logic [2:0] mode_select_pins, // strapped mode pins
    output logic nmi_pin                 // nmi line
);
    // strap only changes while reset is held
    assign mode_select_pins = strap;
    assign nmi_pin = nmi_lvl;
endmodule // omc_ext_model
`default_nettype wire

// File: dv/omc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module omc_top_asserts
    import omc_pkg::*;
(
    input wire logic clock,            // system clock
    input wire logic rst,              // reset
    input wire omc_pkg::omc_req_s req, // register request
    input wire logic [7:0] rdata,      // read data
    input wire omc_pkg::omc_cfg_s cfg, // configuration
    input wire omc_pkg::omc_pins_s pins, // pin functions
    input wire logic [2:0] mode        // latched mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_space; mode != 3'h0 |-> cfg.advanced == (mode > 3'h3); endproperty
    a_space: assert property (p_space) else $error("address space wrong");
    property p_areas; mode != 3'h0 |-> cfg.eight_areas == cfg.advanced; endproperty
    a_areas: assert property (p_areas) else $error("area split wrong");
    property p_rom; mode != 3'h0 |-> cfg.rom_enable == (mode inside {2, 3, 6, 7}); endproperty
    a_rom: assert property (p_rom) else $error("rom enable wrong");
    property p_single; mode != 3'h0 |-> cfg.ext_allowed == !(mode inside {3, 7}); endproperty
    a_single: assert property (p_single) else $error("external access wrong");
    property p_kb; mode inside {2, 3} |-> cfg.rom_kbytes == 8'd56; endproperty
    a_kb: assert property (p_kb) else $error("rom limit wrong");
    property p_ramext; cfg.ram_to_external |-> !cfg.ram_enable; endproperty
    a_ramext: assert property (p_ramext) else $error("ram routed while on");
    property p_rsv; req.rd && req.addr == OMC_ADDR_SYSCTL |=> rdata[2] == 1'b0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit read one");
    property p_ramwr;
        req.wr && req.addr == OMC_ADDR_SYSCTL |=> cfg.ram_enable == $past(req.wdata[0]);
    endproperty
    a_ramwr: assert property (p_ramwr) else $error("ram enable not written");
    property p_portf; mode inside {1, 2, 4, 5, 6} |-> pins.f[6] == OMC_PIN_CTRL; endproperty
    a_portf: assert property (p_portf) else $error("port f not control");
    property p_portf7; mode inside {1, 2, 4, 5, 6} |-> pins.f[7] == OMC_PIN_CTRL; endproperty
    a_portf7: assert property (p_portf7) else $error("port f top pin not control");
    property p_rdidle; !req.rd |=> rdata == 8'h00; endproperty
    a_rdidle: assert property (p_rdidle) else $error("read data not idle");
    property p_bus16; cfg.bus16 && mode inside {1, 2, 5} |-> pins.e[0] == OMC_PIN_DATA; endproperty
    a_bus16: assert property (p_bus16) else $error("port e not data");
endmodule // omc_top_asserts
bind omc_top omc_top_asserts omc_top_asserts_inst (.clock(clock), .rst(rst), .req(req),
    .rdata(rdata), .cfg(cfg), .pins(pins), .mode(mode));
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import omc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic standby = 1'b0;
    logic nmi_lvl = 1'b1;
    logic [2:0] strap = 3'h1;
    logic [7:0] ddr_a = 8'h00, ddr_b = 8'h00, ddr_c = 8'h00;
    omc_req_s req = '0;
    logic [7:0] rdata, rd_v;
    omc_cfg_s cfg;
    omc_pins_s pins;
    logic nmi_request, adv, rom, expd;
    logic [2:0] mode;
    wire logic [2:0] mode_select_pins;
    wire logic nmi_pin;
    int failures = 0, checks_done = 0, cyc = 0;
    always #5 clock = ~clock;
    omc_ext_model omc_ext_model_inst (.strap(strap), .nmi_lvl(nmi_lvl),
        .mode_select_pins(mode_select_pins), .nmi_pin(nmi_pin));
    omc_top omc_top_inst (.clock(clock), .rst(rst), .mode_select_pins(mode_select_pins),
        .nmi_pin(nmi_pin), .standby(standby), .ddr_a(ddr_a), .ddr_b(ddr_b), .ddr_c(ddr_c),
        .req(req), .rdata(rdata), .cfg(cfg), .pins(pins), .nmi_request(nmi_request),
        .mode(mode));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 rd_v = rdata;
    endtask
    task automatic nmi_edge(input logic lvl, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge clock);
        nmi_lvl <= lvl;
        repeat (6) begin
            @(posedge clock);
            #1 seen = seen | nmi_request;
        end
        chk("nmi", {7'h0, seen}, {7'h0, exp});
    endtask
    task automatic boot(input logic [2:0] m);
        @(posedge clock);
        rst <= 1'b1;
        strap <= m;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            end_sim;
        end
    end
    initial begin
        for (int m = 1; m < 8; m++) begin
            boot(m[2:0]);
            adv = m > 3;
            rom = m inside {2, 3, 6, 7};
            expd = !(m inside {3, 7});
            chk("mode", {5'h0, mode}, m[7:0]);
            chk("adv", {7'h0, cfg.advanced}, {7'h0, adv});
            chk("areas", {7'h0, cfg.eight_areas}, {7'h0, adv});
            chk("rom", {7'h0, cfg.rom_enable}, {7'h0, rom});
            chk("ext", {7'h0, cfg.ext_allowed}, {7'h0, expd});
            chk("kb", cfg.rom_kbytes, 8'(!rom ? 0 : (m < 4 ? 56 : 64)));
            chk("bus16", {7'h0, cfg.bus16}, {7'h0, m == 4});
            chk("pf6", {6'h0, pins.f[6]}, {6'h0, expd ? OMC_PIN_CTRL : OMC_PIN_IO});
            chk("pf7", {6'h0, pins.f[7]}, {6'h0, expd ? OMC_PIN_CTRL : OMC_PIN_IO});
            rd(OMC_ADDR_MODE);
            chk("mode reg", rd_v, m[7:0]);
            rd(OMC_ADDR_STATUS);
            chk("status", rd_v, {3'h0, 1'b1, expd, m == 4, rom, adv});
            if (m == 2 || m == 6) begin
                chk("pb0 in", {6'h0, pins.b[0]}, {6'h0, OMC_PIN_IO});
                @(posedge clock);
                ddr_a <= 8'h01;
                ddr_b <= 8'h01;
                ddr_c <= 8'h01;
                @(posedge clock);
                #1;
                chk("pb0 out", {6'h0, pins.b[0]}, {6'h0, OMC_PIN_ADDR});
                chk("pc0 out", {6'h0, pins.c[0]}, {6'h0, OMC_PIN_ADDR});
                chk("pa0", {6'h0, pins.a[0]}, {6'h0, m == 6 ? OMC_PIN_ADDR : OMC_PIN_IO});
                chk("pb1", {6'h0, pins.b[1]}, {6'h0, OMC_PIN_IO});
                @(posedge clock);
                ddr_a <= 8'h00;
                ddr_b <= 8'h00;
                ddr_c <= 8'h00;
            end
            if (expd) begin
                wr(OMC_ADDR_AREAW, m == 4 ? 8'h00 : 8'h80);
                chk("bus16 w", {7'h0, cfg.bus16}, {7'h0, m != 4});
                chk("pe0", {6'h0, pins.e[0]}, {6'h0, m == 4 ? OMC_PIN_IO : OMC_PIN_DATA});
            end
            if (m > 5) begin
                chk("rsv", {7'h0, cfg.upper_rom_reserved}, 8'h01);
                wr(OMC_ADDR_EXTCTL, 8'h00);
                chk("kb ext", cfg.rom_kbytes, 8'd128);
                chk("rsv ext", {7'h0, cfg.upper_rom_reserved}, 8'h00);
            end
            if (m == 6) begin
                rd(OMC_ADDR_SYSCTL);
                chk("sys rst", rd_v, 8'h01);
                nmi_edge(1'b0, 1'b1);
                nmi_edge(1'b1, 1'b0);
                wr(OMC_ADDR_SYSCTL, 8'hfc);
                rd(OMC_ADDR_SYSCTL);
                chk("sys", rd_v, 8'hb8);
                chk("ram", {7'h0, cfg.ram_enable}, 8'h00);
                chk("ram ext", {7'h0, cfg.ram_to_external}, 8'h01);
                @(posedge clock);
                standby <= 1'b1;
                nmi_edge(1'b0, 1'b0);
                nmi_edge(1'b1, 1'b1);
                chk("ram sby", {7'h0, cfg.ram_enable}, 8'h00);
                @(posedge clock);
                standby <= 1'b0;
                rd(OMC_ADDR_NMI);
                chk("nmi pend", rd_v, 8'h01);
                wr(OMC_ADDR_NMI, 8'h01);
                rd(OMC_ADDR_NMI);
                chk("nmi clr", rd_v, 8'h00);
                rd(4'hf);
                chk("unmapped", rd_v, 8'h00);
                @(posedge clock);
                #1;
                chk("rdata idle", rdata, 8'h00);
            end
            $display("test mode %0d done", m);
        end
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
